// >>> logic/rtc_sec_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_sec_map.svh"
module rtc_sec_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic countClk,
  input wire logic [15:0] addr,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData,
  input wire logic accessHoldRequest,
  output logic accessHoldStatus,
  output logic secondsCarry,
  output logic [15:0] subsecondCounter,
  output logic [7:0] secondsBcdCounter
);
  typedef struct packed {
    logic [2:0] clkSync;
    logic [1:0] holdSync;
    logic [15:0] subsec;
    logic [7:0] secBuf;
    rtc_sec_pkg::xfer_t xfer;
    logic [1:0] xferCnt;
    logic hold;
    logic [15:0] frzSub;
    logic [7:0] frzSec;
    logic [15:0] rdData;
  } top_t;
  top_t st, next_st;
  rtc_sec_if sif();
  logic tick;
  logic secWr;

  ////////////////////////////////////////////////////////////////////////
  // Count-clock edge detection after a two-stage synchroniser
  assign tick = st.clkSync[1] & ~st.clkSync[2];
  assign secWr = wrStb && addr == `ADDR_SECONDS;

  always_comb begin
    next_st = st;
    next_st.clkSync = {st.clkSync[1:0], countClk};
    next_st.holdSync = {st.holdSync[0], accessHoldRequest};
    // Wraps from 7fffh back to 0000h; values past 7fffh would just keep counting
    if (tick) begin
      next_st.subsec = (st.subsec == `SUBSEC_LAST) ? `SUBSEC_RESET :
        st.subsec + 16'h0001;
    end
    // Buffered seconds write, counted in count-clock ticks
    case (st.xfer)
      rtc_sec_pkg::IDLE: begin
      end
      rtc_sec_pkg::PEND: begin
        if (tick) begin
          next_st.xferCnt = st.xferCnt + 2'h1;
          if (st.xferCnt + 2'h1 >= `XFER_DELAY) begin
            next_st.xfer = rtc_sec_pkg::WAIT1;
          end
        end
      end
      rtc_sec_pkg::WAIT1: begin
        next_st.xfer = rtc_sec_pkg::IDLE;
        next_st.subsec = `SUBSEC_RESET;
      end
      default: next_st.xfer = rtc_sec_pkg::IDLE;
    endcase
    if (secWr) begin
      next_st.secBuf = {1'b0, wrData[6:0]};
      next_st.xfer = rtc_sec_pkg::PEND;
      next_st.xferCnt = 2'h0;
      next_st.subsec = `SUBSEC_RESET;
    end
    // Snapshot taken as hold rises, so all reads match one instant
    next_st.hold = st.holdSync[1];
    if (st.holdSync[1] && !st.hold) begin
      next_st.frzSub = st.subsec;
      next_st.frzSec = sif.secOut;
    end
    if (rdStb) begin
      if (addr == `ADDR_SUBSECOND) begin
        next_st.rdData = st.hold ? st.frzSub : st.subsec;
      end else if (addr == `ADDR_SECONDS) begin
        next_st.rdData = {8'h00, st.hold ? st.frzSec : sif.secOut};
      end else begin
        next_st.rdData = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.xfer <= rtc_sec_pkg::IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign sif.tick = tick && st.subsec == `SUBSEC_LAST;
  assign sif.secIn = st.secBuf;
  assign sif.load = st.xfer == rtc_sec_pkg::WAIT1;
  rtc_sec_counter u_cnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus(sif.cnt)
  );

  assign rdData = st.rdData;
  assign accessHoldStatus = st.hold;
  assign secondsCarry = sif.carry;
  assign subsecondCounter = st.subsec;
  assign secondsBcdCounter = sif.secOut;

  ////////////////////////////////////////////////////////////////////////
  // Sub-second counting
  AST_SUBSEC_WRAP: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    tick && st.subsec == `SUBSEC_LAST && !secWr |=>
    st.subsec == `SUBSEC_RESET)
    else $error("sub-second wrap wrong");
  AST_SUBSEC_STEP: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    tick && !secWr && !sif.load && st.subsec != `SUBSEC_LAST |=>
    st.subsec == $past(st.subsec) + 16'h0001)
    else $error("sub-second did not step");
  AST_SUBSEC_IDLE: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !tick && !secWr && !sif.load |=> $stable(st.subsec))
    else $error("sub-second moved without a tick");
  AST_WR_CLEARS: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    secWr |=> st.subsec == `SUBSEC_RESET)
    else $error("seconds write did not clear sub-second");
  AST_LOAD_CLEARS: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    sif.load |=> st.subsec == `SUBSEC_RESET)
    else $error("transfer did not clear sub-second");

  // Buffered seconds write and seconds carry
  AST_BUF_CAPTURE: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    secWr |=> st.secBuf == {1'b0, $past(wrData[6:0])})
    else $error("write buffer wrong");
  AST_XFER_BOUND: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    st.xfer == rtc_sec_pkg::PEND && tick && !secWr &&
    st.xferCnt == `XFER_DELAY - 2'h1 |=> sif.load)
    else $error("buffered write not moved after two ticks");
  AST_XFER_LAND: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    sif.load |=> secondsBcdCounter == $past(sif.secIn))
    else $error("buffered write lost");
  AST_BIT7_ZERO: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    secondsBcdCounter[7] == 1'b0)
    else $error("seconds bit 7 set");
  AST_CARRY_59: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    secondsCarry |-> $past(sif.tick))
    else $error("carry without overflow");
  AST_CARRY_ONE: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    secondsCarry |=> !secondsCarry)
    else $error("carry longer than one cycle");

  // Access hold and readback
  AST_HOLD_STATUS: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    st.holdSync[1] |=> accessHoldStatus)
    else $error("hold status not raised");
  AST_HOLD_RELEASE: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !st.holdSync[1] |=> !accessHoldStatus)
    else $error("hold status not cleared");
  AST_HOLD_SNAP: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    st.holdSync[1] && !st.hold |=> st.frzSec == $past(sif.secOut))
    else $error("seconds snapshot wrong");
  AST_HOLD_FREEZE: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    st.hold && $past(st.hold) |-> $stable(st.frzSec))
    else $error("frozen seconds moved");
  AST_READ_HELD: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    rdStb && addr == `ADDR_SECONDS && st.hold |=> rdData[7:0] == st.frzSec)
    else $error("held read wrong");
  AST_READ_LIVE: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    rdStb && addr == `ADDR_SUBSECOND && !st.hold |=>
    rdData == $past(st.subsec))
    else $error("live sub-second read wrong");
  AST_READ_UNMAPPED: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    rdStb && addr != `ADDR_SUBSECOND && addr != `ADDR_SECONDS |=>
    rdData == '0)
    else $error("unmapped read not zero");
  AST_READ_STANDS: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !rdStb |=> $stable(rdData))
    else $error("read data changed without a read");

  // Main scenarios
  COV_WRITE: cover property (@(posedge sys_clk) secWr);
  COV_CARRY: cover property (@(posedge sys_clk) secondsCarry);
  COV_HOLD: cover property (@(posedge sys_clk) st.hold && rdStb);
  COV_LOAD: cover property (@(posedge sys_clk) sif.load);
  COV_RELEASE: cover property (@(posedge sys_clk) st.hold && !st.holdSync[1]);
endmodule
`default_nettype wire

// >>> logic/rtc_sec_map.svh
`ifndef RTC_SEC_MAP_SVH
`define RTC_SEC_MAP_SVH
`define ADDR_SUBSECOND 16'hffb0
`define ADDR_SECONDS 16'hffb2
`define SUBSEC_RESET 16'h0000
`define SUBSEC_LAST 16'h7fff
`define SEC_RESET 8'h00
`define SEC_TENS_MAX 3'h5
`define SEC_UNITS_MAX 4'h9
`define XFER_DELAY 2'h2
`endif

// >>> logic/rtc_sec_pkg.sv
package rtc_sec_pkg;
  typedef enum logic [1:0] {IDLE, PEND, WAIT1} xfer_t;
endpackage

// >>> logic/rtc_sec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rtc_sec_if;
  logic tick;
  logic [7:0] secIn;
  logic load;
  logic [7:0] secOut;
  logic carry;
  modport ctrl (output tick, output secIn, output load, input secOut,
    input carry);
  modport cnt (input tick, input secIn, input load, output secOut,
    output carry);
endinterface
`default_nettype wire

// >>> logic/rtc_sec_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_sec_map.svh"
module rtc_sec_counter (
  input wire logic sys_clk,
  input wire logic rst_n,
  rtc_sec_if.cnt bus
);
  typedef struct packed {
    logic [7:0] sec;
    logic carry;
  } cnt_t;
  cnt_t st, next_st;
  logic [2:0] tens;
  logic [3:0] units;
  assign tens = st.sec[6:4];
  assign units = st.sec[3:0];

  always_comb begin
    next_st = st;
    next_st.carry = 1'b0;
    if (bus.load) begin
      next_st.sec = {1'b0, bus.secIn[6:0]};
    end else if (bus.tick) begin
      // Out-of-range digits fold back within one count
      // Tens past five can only come from a bad write: wrap at once
      if (tens > `SEC_TENS_MAX ||
        (tens >= `SEC_TENS_MAX && units >= `SEC_UNITS_MAX)) begin
        next_st.sec = `SEC_RESET;
        next_st.carry = 1'b1;
      end else if (units >= `SEC_UNITS_MAX) begin
        next_st.sec = {1'b0, tens + 3'h1, 4'h0};
      end else begin
        next_st.sec = {1'b0, tens, units + 4'h1};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{sec: `SEC_RESET, carry: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  assign bus.secOut = st.sec;
  assign bus.carry = st.carry;

  AST_BCD_VALID: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    $past(bus.tick) && !$past(bus.load) |->
    st.sec[3:0] <= `SEC_UNITS_MAX && st.sec[6:4] <= `SEC_TENS_MAX)
    else $error("seconds digits not folded");
  AST_WRAP: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    st.carry |-> st.sec == `SEC_RESET)
    else $error("carry without wrap");
endmodule
`default_nettype wire

// >>> test/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input wire logic sys_clk,
  input wire logic [15:0] rdData,
  output logic [15:0] addr,
  output logic wrStb,
  output logic rdStb,
  output logic [15:0] wrData,
  output logic accessHoldRequest,
  output logic countClk
);
  logic run = 1'b0;
  initial begin
    addr = 16'h0000;
    wrStb = 1'b0;
    rdStb = 1'b0;
    wrData = 16'h0000;
    accessHoldRequest = 1'b0;
    countClk = 1'b0;
  end
  // Count clock sped to 2 sys_clk cycles so one second fits the run
  always @(negedge sys_clk) begin
    if (run) begin
      countClk <= ~countClk;
    end
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    addr = a;
    wrData = d;
    wrStb = 1'b1;
    @(negedge sys_clk);
    wrStb = 1'b0;
    wrData = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    addr = a;
    rdStb = 1'b1;
    @(negedge sys_clk);
    rdStb = 1'b0;
    @(negedge sys_clk);
    d = rdData;
  endtask
  // Whole hold sequence kept far below one second
  task automatic hold(input logic on);
    @(negedge sys_clk);
    accessHoldRequest = on;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr, wrData, rdData, subsecondCounter, d, e;
  logic wrStb, rdStb, holdReq, holdStat, secondsCarry, countClk;
  logic [7:0] secondsBcdCounter;
  int fail_count = 0;
  int compares = 0;
  int carries = 0;
  always #20 sys_clk = ~sys_clk;
  // Counted mid-cycle, away from the edge that launches the pulse
  always @(negedge sys_clk) begin
    if (secondsCarry === 1'b1) begin
      carries <= carries + 1;
    end
  end
  cpu_model cpu (.sys_clk(sys_clk), .rdData(rdData), .addr(addr),
    .wrStb(wrStb), .rdStb(rdStb), .wrData(wrData),
    .accessHoldRequest(holdReq), .countClk(countClk));
  rtc_sec_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .countClk(countClk),
    .addr(addr), .wrStb(wrStb), .rdStb(rdStb), .wrData(wrData),
    .rdData(rdData), .accessHoldRequest(holdReq),
    .accessHoldStatus(holdStat), .secondsCarry(secondsCarry),
    .subsecondCounter(subsecondCounter),
    .secondsBcdCounter(secondsBcdCounter));
  task automatic chk(input string n, input logic [15:0] x,
    input logic [15:0] s);
    compares++;
    if (s !== x) begin
      $display("mismatch %s expected %h seen %h", n, x, s);
      fail_count++;
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(80000 * 40);
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    cpu.rd(16'hffb0, d);
    chk("subsecond", 16'h0000, d);
    cpu.rd(16'hffb2, d);
    chk("seconds", 16'h0000, d);
    cpu.wr(16'hffb0, 16'h1234);
    cpu.rd(16'hffb0, d);
    chk("subro", 16'h0000, d);
    cpu.run = 1'b1;
    cpu.wr(16'hffb2, 16'h00d8);
    // Two count periods plus synchroniser and transfer latency
    repeat (7) @(negedge sys_clk);
    chk("seconds", 16'h0058, {8'h00, secondsBcdCounter});
    chk("subclear", 16'h0000, subsecondCounter & 16'hfff8);
    cpu.hold(1'b1);
    chk("hold", 16'h0001, {15'h0, holdStat});
    cpu.rd(16'hffb2, d);
    chk("heldsec", 16'h0058, d);
    cpu.rd(16'hffb0, d);
    repeat (20) @(negedge sys_clk);
    cpu.rd(16'hffb0, e);
    chk("frozen", d, e);
    cpu.rd(16'h1234, d);
    chk("unmapped", 16'h0000, d);
    cpu.hold(1'b0);
    chk("release", 16'h0000, {15'h0, holdStat});
    cpu.wr(16'hffb2, 16'h0059);
    // One second is 32768 count edges, two cycles each
    repeat (65600) @(negedge sys_clk);
    chk("wrap", 16'h0000, {8'h00, secondsBcdCounter});
    chk("carry", 16'h0001, carries[15:0]);
    chk("subwrap", 16'h0000, subsecondCounter & 16'hffc0);
    give_verdict();
  end
endmodule
`default_nettype wire
